// ===== design/bst_consts.svh
// Constants of the boundary-scan test access port
// Overview of operation
// - Port uses a 16-state controller, six-bit instruction and five test pins
// - Low test reset forces Test-Logic-Reset regardless of the test clock
// - Mode select and serial input are sampled on test clock rising edges
// - Serial output changes on test clock falling edges
// - Serial output is driven only in Shift-DR and Shift-IR
// - State advances by the mode select level at each rising edge
// - Five rising edges with mode select high reach Test-Logic-Reset
// - Serial input feeds whichever register the controller currently selects
// - Inputs get observe cells, outputs control cells, bidirectional pins both
// - Static boundary scan covers the directly coupled pins
// - AC test mode drives a time-varying value through coupled outputs
// - Identification register is readable through the serial path
// - Opcodes 000000 extest, 000001 sample/preload, 000010 identification
// - Opcode 000011 tri-states, 111110 clamps with bypass, 111111 bypass
// - Capture-IR loads the fixed pattern 101101
// - Shifted instruction becomes active only at Update-IR
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

`define BST_IR_W          6
`define BST_OP_EXTEST     6'h00
`define BST_OP_SAMPLE     6'h01
`define BST_OP_IDCODE     6'h02
`define BST_OP_HIGHZ      6'h03
`define BST_OP_CAPTURE    6'h2D
`define BST_OP_AC_TRAIN   6'h3C
`define BST_OP_AC_PULSE   6'h3D
`define BST_OP_CLAMP      6'h3E
`define BST_OP_BYPASS     6'h3F
`define BST_ID_W          32
`define BST_N_IN          8
`define BST_N_OUT         8
`define BST_N_BI          13
`define BST_BI_MASTER_MGMT_BUS_CLOCK 0
`define BST_BI_MASTER_MGMT_BUS_DATA  1
`define BST_BI_SLAVE_MGMT_BUS_CLOCK  2
`define BST_BI_SLAVE_MGMT_BUS_DATA   3
`define BST_BI_GPIO_BASE  4
`define BST_CHAIN_W       (`BST_N_IN + `BST_N_OUT + 3 * `BST_N_BI)
`define BST_FIFO_DEPTH    16

`endif

// ===== design/bst_pkg.sv
// Types shared by the boundary-scan test access port
package bst_pkg;
	`include "bst_consts.svh"

	// Gray codes along the usual data and instruction paths
	typedef enum logic [3:0] {
		BST_TLR   = 4'h0,
		BST_RTI   = 4'h1,
		BST_SELDR = 4'h3,
		BST_CAPDR = 4'h2,
		BST_SHDR  = 4'h6,
		BST_EX1DR = 4'h7,
		BST_UPDDR = 4'h5,
		BST_SELIR = 4'h4,
		BST_CAPIR = 4'hC,
		BST_SHIR  = 4'hD,
		BST_EX1IR = 4'hF,
		BST_PSIR  = 4'hE,
		BST_EX2IR = 4'hA,
		BST_UPDIR = 4'hB,
		BST_PSDR  = 4'h9,
		BST_EX2DR = 4'h8
	} bst_state_e;

	// Functional drive of the output and bidirectional pads
	typedef struct packed {
		logic [`BST_N_OUT-1:0] out;
		logic [`BST_N_BI-1:0]  bi_out;
		logic [`BST_N_BI-1:0]  bi_oe;
	} bst_drive_s;

	typedef logic [`BST_CHAIN_W-1:0] bst_chain_t;
endpackage

// ===== design/bst_tap.sv
// Boundary-scan test access port with its snapshot FIFO
`timescale 1ns/1ps
`include "bst_consts.svh"

// ****************************************************
// Snapshot FIFO
// ****************************************************
module bst_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [W-1:0] mem_d [D];
	logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
	logic         push, pop;
	assign in_ready  = (wr_q - rd_q) != (AW+1)'(D);
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem_q[rd_q[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	always_comb begin
		mem_d = mem_q;
		wr_d  = wr_q + (AW+1)'(push);
		rd_d  = rd_q + (AW+1)'(pop);
		if (push) begin
			mem_d[wr_q[AW-1:0]] = in_data;
		end
	end
	always_ff @(posedge clk_sys) begin
		mem_q <= mem_d;
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end
endmodule

// ****************************************************
// Test access port
// ****************************************************
module bst_tap import bst_pkg::*; #(
	// Arbitrary neutral identification value; bit 0 must stay one
	parameter logic [`BST_ID_W-1:0] ID_VALUE = 32'h0ABC_D001
) (
	// System clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// Test pins
	input  wire logic                 tck_i,
	input  wire logic                 tms_i,
	input  wire logic                 tdi_i,
	input  wire logic                 trst_n_i,
	output logic                      tdo_o,
	output logic                      tdo_oe,
	// Pads: bits 0..3 are master and slave management bus, rest GPIO
	input  wire logic [`BST_N_IN-1:0] pad_in_i,
	output logic [`BST_N_OUT-1:0]     pad_out_o,
	input  wire logic [`BST_N_BI-1:0] pad_bi_i,
	output logic [`BST_N_BI-1:0]      pad_bi_o,
	output logic [`BST_N_BI-1:0]      pad_bi_oe,
	// Core side of the pads
	input  wire bst_drive_s           core_drive_i,
	output logic [`BST_N_IN-1:0]      core_in_o,
	output logic [`BST_N_BI-1:0]      core_bi_o,
	// Stream of chain contents taken at each boundary Update-DR
	output logic                      snap_valid,
	input  wire logic                 snap_ready,
	output bst_chain_t                snap_data,
	output logic                      snap_room,
	output logic                      snap_overflow
);
	localparam int NI = `BST_N_IN;
	localparam int NO = `BST_N_OUT;
	localparam int NB = `BST_N_BI;
	localparam int CW = `BST_CHAIN_W;
	// ****************************************************
	// Pin synchronisers
	// ****************************************************
	logic [3:0]    pin_s1_q, pin_s2_q;
	logic [NI-1:0] in_s1_q, in_s2_q;
	logic [NB-1:0] bi_s1_q, bi_s2_q;
	logic          tck_prev_q;
	logic          tck_rise, tck_fall, tms, tdi, trst_act;
	always_ff @(posedge clk_sys) begin
		pin_s1_q   <= {trst_n_i, tdi_i, tms_i, tck_i};
		pin_s2_q   <= pin_s1_q;
		in_s1_q    <= pad_in_i;
		in_s2_q    <= in_s1_q;
		bi_s1_q    <= pad_bi_i;
		bi_s2_q    <= bi_s1_q;
		tck_prev_q <= rst_n ? pin_s2_q[0] : 1'b0;
	end
	assign tck_rise = pin_s2_q[0] & ~tck_prev_q;
	assign tck_fall = ~pin_s2_q[0] & tck_prev_q;
	assign tms      = pin_s2_q[1];
	assign tdi      = pin_s2_q[2];
	// Level reset, acts on every system edge with no test clock needed
	assign trst_act = ~pin_s2_q[3] | ~rst_n;
	// ****************************************************
	// Controller and registers
	// ****************************************************
	bst_state_e                st_q, st_d;
	logic [`BST_IR_W-1:0]      irs_q, irs_d, ir_q, ir_d;
	logic [`BST_ID_W-1:0]      ids_q, ids_d;
	logic                      byp_q, byp_d;
	bst_chain_t                bsr_q, bsr_d, upd_q, upd_d, cap;
	logic                      ac_q, ac_d;
	logic                      sel_bsr, sel_id, upd_push;
	always_comb begin
		sel_bsr = ir_q == `BST_OP_EXTEST || ir_q == `BST_OP_SAMPLE ||
			ir_q == `BST_OP_AC_TRAIN || ir_q == `BST_OP_AC_PULSE;
		sel_id  = ir_q == `BST_OP_IDCODE;
	end
	// Capture values in chain order: inputs, outputs, then per bidir pin
	// its data, enable and observe cells
	genvar gi;
	generate
		for (gi = 0; gi < CW; gi++) begin : g_cap
			if (gi < NI) begin : g_i
				assign cap[gi] = in_s2_q[gi];
			end else if (gi < NI + NO) begin : g_o
				assign cap[gi] = core_drive_i.out[gi-NI];
			end else begin : g_b
				localparam int B = (gi - NI - NO) / 3;
				localparam int K = (gi - NI - NO) % 3;
				if (K == 0) begin : g_d
					assign cap[gi] = core_drive_i.bi_out[B];
				end else if (K == 1) begin : g_e
					assign cap[gi] = core_drive_i.bi_oe[B];
				end else begin : g_c
					assign cap[gi] = bi_s2_q[B];
				end
			end
		end
	endgenerate
	always_comb begin
		st_d     = st_q;
		irs_d    = irs_q;
		ir_d     = ir_q;
		ids_d    = ids_q;
		byp_d    = byp_q;
		bsr_d    = bsr_q;
		upd_d    = upd_q;
		ac_d     = ac_q;
		upd_push = 1'b0;
		if (tck_rise) begin
			case (st_q)
			BST_TLR:   st_d = tms ? BST_TLR   : BST_RTI;
			BST_RTI:   st_d = tms ? BST_SELDR : BST_RTI;
			BST_SELDR: st_d = tms ? BST_SELIR : BST_CAPDR;
			BST_CAPDR: st_d = tms ? BST_EX1DR : BST_SHDR;
			BST_SHDR:  st_d = tms ? BST_EX1DR : BST_SHDR;
			BST_EX1DR: st_d = tms ? BST_UPDDR : BST_PSDR;
			BST_PSDR:  st_d = tms ? BST_EX2DR : BST_PSDR;
			BST_EX2DR: st_d = tms ? BST_UPDDR : BST_SHDR;
			BST_UPDDR: st_d = tms ? BST_SELDR : BST_RTI;
			BST_SELIR: st_d = tms ? BST_TLR   : BST_CAPIR;
			BST_CAPIR: st_d = tms ? BST_EX1IR : BST_SHIR;
			BST_SHIR:  st_d = tms ? BST_EX1IR : BST_SHIR;
			BST_EX1IR: st_d = tms ? BST_UPDIR : BST_PSIR;
			BST_PSIR:  st_d = tms ? BST_EX2IR : BST_PSIR;
			BST_EX2IR: st_d = tms ? BST_UPDIR : BST_SHIR;
			BST_UPDIR: st_d = tms ? BST_SELDR : BST_RTI;
			default:   st_d = BST_TLR;
			endcase
			case (st_q)
			BST_TLR: begin
				ir_d = `BST_OP_IDCODE;
			end
			BST_RTI: begin
				// Coupled outputs toggle each idle clock in train mode
				ac_d = (ir_q == `BST_OP_AC_TRAIN) & ~ac_q;
			end
			BST_CAPDR: begin
				byp_d = 1'b0;
				ids_d = ID_VALUE;
				bsr_d = cap;
			end
			BST_SHDR: begin
				if (sel_bsr) begin
					bsr_d = {tdi, bsr_q[CW-1:1]};
				end else if (sel_id) begin
					ids_d = {tdi, ids_q[`BST_ID_W-1:1]};
				end else begin
					byp_d = tdi;
				end
			end
			BST_UPDDR: begin
				if (sel_bsr) begin
					upd_d    = bsr_q;
					upd_push = 1'b1;
				end
			end
			BST_CAPIR: begin
				irs_d = `BST_OP_CAPTURE;
			end
			BST_SHIR: begin
				irs_d = {tdi, irs_q[`BST_IR_W-1:1]};
			end
			BST_UPDIR: begin
				ir_d = irs_q;
				ac_d = 1'b0;
			end
			default: begin
			end
			endcase
		end
		if (trst_act) begin
			st_d = BST_TLR;
			ir_d = `BST_OP_IDCODE;
			ac_d = 1'b0;
		end
	end
	always_ff @(posedge clk_sys) begin
		st_q  <= st_d;
		irs_q <= irs_d;
		ir_q  <= ir_d;
		ac_q  <= ac_d;
		ids_q <= ids_d;
		byp_q <= byp_d;
		bsr_q <= bsr_d;
		upd_q <= upd_d;
	end
	// ****************************************************
	// Serial output on the falling test clock edge
	// ****************************************************
	logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
	always_comb begin
		tdo_d    = tdo_q;
		tdo_oe_d = tdo_oe_q;
		if (tck_fall) begin
			tdo_oe_d = st_q == BST_SHDR || st_q == BST_SHIR;
			if (st_q == BST_SHIR) begin
				tdo_d = irs_q[0];
			end else if (sel_bsr) begin
				tdo_d = bsr_q[0];
			end else if (sel_id) begin
				tdo_d = ids_q[0];
			end else begin
				tdo_d = byp_q;
			end
		end
		if (trst_act) begin
			tdo_oe_d = 1'b0;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tdo_q    <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_q    <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
		end
	end
	assign tdo_o  = tdo_q;
	assign tdo_oe = tdo_oe_q;
	// ****************************************************
	// Pad drive
	// ****************************************************
	bst_drive_s drv_q, drv_d, tst;
	logic       test_drv, highz, pulse;
	generate
		for (gi = 0; gi < NB; gi++) begin : g_bi
			assign tst.bi_out[gi] = upd_q[NI + NO + 3*gi];
			assign tst.bi_oe[gi]  = upd_q[NI + NO + 3*gi + 1];
		end
	endgenerate
	// Whole struct is driven by continuous assigns, never procedurally
	assign tst.out = upd_q[NI +: NO] ^ {NO{ac_q | pulse}};
	always_comb begin
		test_drv = ir_q == `BST_OP_EXTEST || ir_q == `BST_OP_CLAMP ||
			ir_q == `BST_OP_AC_TRAIN || ir_q == `BST_OP_AC_PULSE;
		highz    = ir_q == `BST_OP_HIGHZ;
		// Pulse mode inverts the coupled outputs while idling
		pulse    = ir_q == `BST_OP_AC_PULSE && st_q == BST_RTI;
		drv_d    = test_drv ? tst : core_drive_i;
		if (highz) begin
			drv_d.bi_oe = '0;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			drv_q <= '0;
		end else begin
			drv_q <= drv_d;
		end
	end
	// Tri-stated output-only pads are modelled as driving low
	assign pad_out_o = highz ? '0 : drv_q.out;
	assign pad_bi_o  = drv_q.bi_out;
	assign pad_bi_oe = drv_q.bi_oe;
	assign core_in_o = in_s2_q;
	assign core_bi_o = bi_s2_q;
	// ****************************************************
	// Snapshot stream
	// ****************************************************
	// The test clock cannot be stalled, so a full FIFO drops the word
	// and raises a sticky flag cleared only by system reset
	logic ovf_q, ovf_d;
	always_comb begin
		ovf_d = ovf_q | (upd_push & ~snap_room);
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= ovf_d;
		end
	end
	assign snap_overflow = ovf_q;
	bst_fifo #(
		.W (CW),
		.D (`BST_FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (upd_push),
		.in_ready  (snap_room),
		.in_data   (bsr_q),
		.out_valid (snap_valid),
		.out_ready (snap_ready),
		.out_data  (snap_data)
	);
endmodule

// ===== dv/bst_ctl.sv
// Board test controller model driving the test pins
`timescale 1ns/1ps
module bst_ctl (
	// Clock
	input  wire logic clk_sys,
	// Test pins
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_n,
	input  wire logic tdo_w
);
	// ****
	// Pin sequencing
	// ****
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_n = 1'b1;
	end
	// One test clock period; tck stands low between calls
	task automatic step(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clk_sys);
		tck <= 1'b1;
		repeat (4) @(posedge clk_sys);
		// Late capture covers the device's pin synchroniser delay
		q = tdo_w;
		tck <= 1'b0;
	endtask
	// From Run-Test/Idle: scan n bits LSB first, back to Run-Test/Idle
	task automatic scan(input logic ir, input logic [63:0] v,
		input int n, output logic [63:0] r);
		logic q;
		r = 64'h0;
		step(1'b1, 1'b0, q);
		if (ir)
			step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		if (n == 0)
			step(1'b1, 1'b0, q);
		else
			step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[i], q);
			r[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	task automatic trst_pulse();
		trst_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		trst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule

// ===== dv/bst_tap_sva.sv
// Concurrent checks on the test pins and snapshot stream
`timescale 1ns/1ps
module bst_tap_sva import bst_pkg::*; (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// Test pins
	input wire logic       tck_i,
	input wire logic       tms_i,
	input wire logic       trst_n_i,
	input wire logic       tdo_o,
	input wire logic       tdo_oe,
	// Snapshot stream
	input wire logic       snap_valid,
	input wire logic       snap_ready,
	input wire bst_chain_t snap_data,
	input wire logic       snap_room,
	input wire logic       snap_overflow
);
	// ****
	// Test clock edge tracking
	// ****
	logic       tck_q;
	logic [3:0] fall_q, fall_d;
	logic [2:0] ones_q, ones_d;
	always_comb begin
		fall_d = (fall_q == 4'hF) ? fall_q : fall_q + 4'h1;
		ones_d = ones_q;
		if (!tck_i && tck_q)
			fall_d = 4'h0;
		// Saturates so a long run of ones cannot wrap
		if (tck_i && !tck_q)
			ones_d = !tms_i ? 3'h0 : (&ones_q) ? ones_q : ones_q + 3'h1;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tck_q  <= 1'b0;
			fall_q <= 4'hF;
			ones_q <= 3'h0;
		end else begin
			tck_q  <= tck_i;
			fall_q <= fall_d;
			ones_q <= ones_d;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence trst_held;
		!trst_n_i [*5];
	endsequence
	// ****
	// Properties
	// ****
	a_tdo_after_fall: assert property (
		$changed(tdo_o) |-> fall_q inside {[4'h1:4'h4]})
		else $error("tdo moved away from a test clock fall");
	a_oe_after_fall: assert property (
		$changed(tdo_oe) |-> fall_q inside {[4'h1:4'h4]})
		else $error("tdo enable moved away from a test clock fall");
	a_trst_quiets_tdo: assert property (
		trst_held |-> !tdo_oe)
		else $error("tdo driven while test reset held");
	a_five_ones_idle: assert property (
		ones_q >= 3'h5 |-> !tdo_oe)
		else $error("tdo driven after five mode-select ones");
	a_snap_held: assert property (
		snap_valid && !snap_ready |=> snap_valid && $stable(snap_data))
		else $error("snapshot word changed before it was taken");
	a_overflow_sticky: assert property (
		snap_overflow |=> snap_overflow)
		else $error("overflow flag cleared without reset");
	a_overflow_cause: assert property (
		$rose(snap_overflow) |-> !$past(snap_room))
		else $error("overflow flagged while room was left");
	a_full_has_data: assert property (
		!snap_room |-> snap_valid)
		else $error("full buffer shows no valid word");
endmodule
bind bst_tap bst_tap_sva i_sva (.clk_sys(clk_sys), .rst_n(rst_n),
	.tck_i(tck_i), .tms_i(tms_i), .trst_n_i(trst_n_i), .tdo_o(tdo_o),
	.tdo_oe(tdo_oe), .snap_valid(snap_valid), .snap_ready(snap_ready),
	.snap_data(snap_data), .snap_room(snap_room),
	.snap_overflow(snap_overflow));

// ===== dv/testbench.sv
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`include "bst_consts.svh"
module testbench;
	import bst_pkg::*;
	// Arbitrary identification value
	localparam logic [31:0] ID = 32'h0ABC_D001;
	localparam logic [54:0] V  = 55'h5A_3C96_0F1E_87D2;
	logic        clk_sys, rst_n, tck, tms, tdi, trst_n;
	logic        tdo_o, tdo_oe, tdo_w, q;
	logic        snap_valid, snap_ready, snap_room, snap_ovf;
	logic [7:0]  pad_in, pad_out, core_in;
	logic [12:0] bi_in, bi_o, bi_oe, core_bi, e_o, e_oe;
	bst_drive_s  core;
	bst_chain_t  snap_data;
	logic [63:0] r;
	int          fail_count, checks_done, n;
	// Released tdo floats up to the board pull-up
	assign tdo_w = tdo_oe ? tdo_o : 1'b1;
	bst_tap #(.ID_VALUE(ID)) i_bst_tap (.clk_sys(clk_sys), .rst_n(rst_n),
		.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
		.tdo_o(tdo_o), .tdo_oe(tdo_oe), .pad_in_i(pad_in),
		.pad_out_o(pad_out), .pad_bi_i(bi_in), .pad_bi_o(bi_o),
		.pad_bi_oe(bi_oe), .core_drive_i(core), .core_in_o(core_in),
		.core_bi_o(core_bi), .snap_valid(snap_valid),
		.snap_ready(snap_ready), .snap_data(snap_data),
		.snap_room(snap_room), .snap_overflow(snap_ovf));
	bst_ctl ctl (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .tdo_w(tdo_w));
	// ****
	// Helpers
	// ****
	task automatic chk(input string nm, input logic [63:0] e, s);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic ir(input logic [5:0] op);
		ctl.scan(1'b1, 64'(op), 6, r);
		// Pad drive is registered one edge after the new instruction
		@(posedge clk_sys);
	endtask
	task automatic dr(input logic [63:0] v, input int k);
		ctl.scan(1'b0, v, k, r);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_ir();
		ir(`BST_OP_BYPASS);
		chk("ir capture", 64'h2D, 64'(r[5:0]));
		dr(64'h96, 8);
		chk("bypass path", 64'h2C, 64'(r[7:0]));
		$display("t_ir done");
	endtask
	// Five ones from inside Shift-DR
	task automatic t_five();
		ir(`BST_OP_BYPASS);
		ctl.step(1'b1, 1'b0, q);
		ctl.step(1'b0, 1'b0, q);
		ctl.step(1'b0, 1'b0, q);
		repeat (5) ctl.step(1'b1, 1'b0, q);
		ctl.step(1'b0, 1'b0, q);
		dr(64'h0, 32);
		chk("id after ones", 64'(ID), 64'(r[31:0]));
		$display("t_five done");
	endtask
	task automatic t_trst();
		ir(`BST_OP_BYPASS);
		ctl.trst_pulse();
		ctl.step(1'b0, 1'b0, q);
		dr(64'h0, 32);
		chk("id after trst", 64'(ID), 64'(r[31:0]));
		$display("t_trst done");
	endtask
	task automatic t_sample();
		pad_in <= 8'hC3;
		bi_in <= 13'h1A5A;
		ir(`BST_OP_SAMPLE);
		dr(64'(V), 55);
		chk("observe", 64'hC3, 64'(r[7:0]));
		chk("snap valid", 64'h1, 64'(snap_valid));
		chk("snap word", 64'(V), 64'(snap_data));
		snap_ready <= 1'b1;
		@(posedge clk_sys);
		snap_ready <= 1'b0;
		@(posedge clk_sys);
		$display("t_sample done");
	endtask
	task automatic t_extest();
		ir(`BST_OP_EXTEST);
		for (int b = 0; b < 13; b++) begin
			e_o[b] = V[16 + 3 * b];
			e_oe[b] = V[17 + 3 * b];
		end
		chk("out pads", 64'(V[15:8]), 64'(pad_out));
		chk("bidir data", 64'(e_o), 64'(bi_o));
		chk("bidir enable", 64'(e_oe), 64'(bi_oe));
		$display("t_extest done");
	endtask
	task automatic t_modes();
		// Non-zero core drive, so that tri-state is visible on the pads
		core <= '{out: 8'h69, bi_out: 13'h0F0F, bi_oe: 13'h1234};
		ir(`BST_OP_HIGHZ);
		chk("highz out", 64'h0, 64'(pad_out));
		chk("highz oe", 64'h0, 64'(bi_oe));
		ir(`BST_OP_CLAMP);
		chk("clamp out", 64'(V[15:8]), 64'(pad_out));
		dr(64'h1, 2);
		chk("clamp bypass", 64'h2, 64'(r[1:0]));
		ir(`BST_OP_AC_PULSE);
		chk("ac pulse", 64'(V[15:8] ^ 8'hFF), 64'(pad_out));
		ir(`BST_OP_AC_TRAIN);
		chk("ac train idle", 64'(V[15:8]), 64'(pad_out));
		ctl.step(1'b0, 1'b0, q);
		@(posedge clk_sys);
		chk("ac train step", 64'(V[15:8] ^ 8'hFF), 64'(pad_out));
		ir(`BST_OP_BYPASS);
		chk("core out", 64'h69, 64'(pad_out));
		chk("core oe", 64'h1234, 64'(bi_oe));
		chk("core bidir in", 64'h1A5A, 64'(core_bi));
		chk("core in", 64'hC3, 64'(core_in));
		$display("t_modes done");
	endtask
	task automatic t_fifo();
		ir(`BST_OP_SAMPLE);
		repeat (16) dr(64'h0, 0);
		chk("full", 64'h0, 64'(snap_room));
		dr(64'h0, 0);
		chk("overflow", 64'h1, 64'(snap_ovf));
		n = 0;
		snap_ready <= 1'b1;
		repeat (40) begin
			@(posedge clk_sys);
			if (snap_valid === 1'b1)
				n++;
		end
		snap_ready <= 1'b0;
		chk("drained", 64'd16, 64'(n));
		$display("t_fifo done");
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (30000) @(posedge clk_sys);
		fail_count++;
		close_out();
	end
	initial begin
		rst_n = 1'b0;
		snap_ready = 1'b0;
		pad_in = 8'h00;
		bi_in = 13'h0000;
		core = '0;
		fail_count = 0;
		checks_done = 0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ctl.step(1'b0, 1'b0, q);
		dr(64'h0, 32);
		chk("idcode", 64'(ID), 64'(r[31:0]));
		t_ir();
		t_five();
		t_trst();
		t_sample();
		t_extest();
		t_modes();
		t_fifo();
		close_out();
	end
endmodule
